// >>> fsps_consts.svh
// constants for the flash self-program sequencer: apb offsets, fields, timing
// assumes inclusion by the design files and the bench only
`ifndef FSPS_CONSTS_SVH
`define FSPS_CONSTS_SVH
`define FSPS_OFF_CTRL      8'h00
`define FSPS_OFF_KEY       8'h04
`define FSPS_OFF_LATCH     8'h08
`define FSPS_OFF_PTR       8'h0C
`define FSPS_OFF_TBLOP     8'h10
`define FSPS_OFF_STATUS    8'h14
`define FSPS_BIT_WR        1
`define FSPS_BIT_WRITE_ENABLE_BIT      2
`define FSPS_BIT_WRITE_ABORT_FLAG     3
`define FSPS_BIT_FREE      4
`define FSPS_BIT_WORD_PROGRAM_SELECT    5
`define FSPS_KEY1          8'h55
`define FSPS_KEY2          8'hAA
`define FSPS_OP_READ       2'h1
`define FSPS_OP_WRITE      2'h2
`define FSPS_PTR_W         22
`define FSPS_HOLD_N        64
`define FSPS_CLK_NS        25
`define FSPS_WRITE_NS      1000000
`define FSPS_ERASE_NS      20000000
`define FSPS_WRITE_CYC     (`FSPS_WRITE_NS / `FSPS_CLK_NS)
`define FSPS_ERASE_CYC     (`FSPS_ERASE_NS / `FSPS_CLK_NS)
`endif

// >>> fsps_pkg.sv
// types for the flash self-program sequencer
// assumes fsps_consts.svh on the include path
package fsps_pkg;
  typedef enum logic [1:0] {FSPS_IDLE, FSPS_ERASE, FSPS_PROG, FSPS_DONE} fsps_state_e;
  typedef logic [21:0] fsps_ptr_t;
endpackage

// >>> fsps_key_det.sv
// unlock key detector: watches key register writes and all other register writes
// assumes pulses from the apb decode of the main sequencer, one clock
`timescale 1ns/1ps
`include "fsps_consts.svh"
module fsps_key_det
(
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       key_wr,
  input  wire logic [7:0] key_data,
  input  wire logic       other_wr,
  output logic            unlocked
);
  import fsps_pkg::*;
  logic [1:0] stage_q;
  logic [1:0] stage_d;

  // any other write breaks the sequence, so the key must be directly followed by start
  always_comb
  begin
    stage_d = stage_q;
    if (other_wr)
      stage_d = 2'h0; // [RULE24]
    else if (key_wr)
      stage_d = (key_data == `FSPS_KEY1) ? 2'h1 :
                ((stage_q == 2'h1) && (key_data == `FSPS_KEY2)) ? 2'h2 : 2'h0; // [RULE8]
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stage_q <= 2'h0;
    else
      stage_q <= stage_d;
  end

  assign unlocked = (stage_q == 2'h2);

  key_order_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE8]
    $rose(unlocked) |-> $past(key_wr) && ($past(key_data) == `FSPS_KEY2))
    else $error("unlock without aa key");
endmodule // fsps_key_det

// >>> fsps_seq.sv
// flash self-program sequencer: table latch, holding buffer, erase and program timing
// assumes an apb master on pclk and a flash array port answering reads combinationally
//
// Summary of operation
// [RULE1] table read puts the one pointed byte into the table latch
// [RULE2] table read may post-increment the byte pointer
// [RULE3] memory is 16-bit words; pointer bit 0 picks low or high byte
// [RULE4] self erase always clears a whole 1024-byte block, never one word
// [RULE5] erase block chosen by pointer bits 21..10; bits 9..0 ignored
// [RULE6] no larger-than-block erase is possible from the core
// [RULE7] core sets write enable and erase select before an erase
// [RULE8] start honoured only after 55h then AAh key writes
// [RULE9] erase is a long write stalling the cpu, ended by the timer
// [RULE10] start with erase selected runs erase for the erase time
// [RULE11] programming unit is 64 bytes, or one 2-byte word
// [RULE12] 64 byte holding registers loaded by table writes only
// [RULE13] core issues up to 64 table writes to fill the holding registers
// [RULE14] core then writes control register to launch programming
// [RULE15] an on-chip timer sets cycle length; pump enable drives high voltage
// [RULE16] start with only write enable runs program for the write time
// [RULE17] holding registers keep contents after programming
// [RULE18] core keeps the pointer within the target 64-byte range
// [RULE19] core programs each byte at most once between erases
// [RULE20] start bit is set-only by software, cleared by hardware at end
// [RULE21] abort flag set on start, cleared on clean timer expiry
// [RULE22] word select picks 2 bytes when set, 64 bytes when clear
// [RULE23] erase select cleared after erase; key register reads zero
// [RULE24] start ignored unless directly after the key; key then rearmed
// [RULE25] start refused while write enable is clear
//
// Our own choices: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "fsps_consts.svh"
module fsps_seq
#(
  parameter int unsigned WRITE_CYC = `FSPS_WRITE_CYC,
  parameter int unsigned ERASE_CYC = `FSPS_ERASE_CYC
)
(
  input  wire logic            pclk,
  input  wire logic            presetn,
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  output fsps_pkg::fsps_ptr_t  flash_addr,
  input  wire logic [15:0]     flash_rdata,
  output logic                 flash_erase,
  output logic                 flash_prog,
  output logic                 flash_word,
  output logic [7:0]           flash_wdata,
  output logic [5:0]           flash_widx,
  output logic                 pump_en,
  output logic                 cpu_stall
);
  import fsps_pkg::*;

  logic [7:0]  hold_q [`FSPS_HOLD_N];
  fsps_ptr_t   ptr_q;
  logic [7:0]  latch_q;
  logic        wr_q, write_enable_bit_q, write_abort_flag_q, free_q, word_program_select_q;
  fsps_state_e state_q;
  logic [31:0] tmr_q;
  logic [6:0]  idx_q;
  logic [31:0] prdata_q;
  logic        pready_q, pslverr_q;

  // apb decode: answer one cycle into the access phase, so each access takes three cycles
  wire acc      = psel && penable && !pready_q;
  wire wr_acc   = acc && pwrite;
  wire rd_acc   = acc && !pwrite;
  wire hit_ctrl = paddr == `FSPS_OFF_CTRL;
  wire hit_key  = paddr == `FSPS_OFF_KEY;
  wire hit_lat  = paddr == `FSPS_OFF_LATCH;
  wire hit_ptr  = paddr == `FSPS_OFF_PTR;
  wire hit_op   = paddr == `FSPS_OFF_TBLOP;
  wire hit_st   = paddr == `FSPS_OFF_STATUS;
  wire mapped   = hit_ctrl | hit_key | hit_lat | hit_ptr | hit_op | hit_st;
  wire busy     = state_q != FSPS_IDLE;
  wire key_wr   = wr_acc && hit_key;
  wire ctrl_wr  = wr_acc && hit_ctrl && !busy;
  wire start_req = ctrl_wr && pwdata[`FSPS_BIT_WR];
  wire unlocked;
  wire start_ok = start_req && unlocked && pwdata[`FSPS_BIT_WRITE_ENABLE_BIT]; // [RULE25]
  wire tbl_rd   = wr_acc && hit_op && !busy && pwdata[1:0] == `FSPS_OP_READ;
  wire tbl_wr   = wr_acc && hit_op && !busy && pwdata[1:0] == `FSPS_OP_WRITE;
  wire post_inc = pwdata[2];
  wire tmr_end  = tmr_q == 32'h0;
  wire [7:0] rd_byte = ptr_q[0] ? flash_rdata[15:8] : flash_rdata[7:0]; // [RULE3]
  wire [7:0] ctrl_rd = {2'h0, word_program_select_q, free_q, write_abort_flag_q, write_enable_bit_q, wr_q, 1'b0};
  wire [31:0] rd_mux = hit_ctrl ? {24'h0, ctrl_rd} :
                       hit_lat  ? {24'h0, latch_q} :
                       hit_ptr  ? {10'h0, ptr_q} :
                       hit_st   ? {30'h0, state_q} : 32'h0; // [RULE23]
  // erase ignores low bits; program targets the 64-byte row around the pointer
  wire fsps_ptr_t erase_base = {ptr_q[21:10], 10'h0}; // [RULE5] [RULE6]

  fsps_key_det u_key
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .key_wr   (key_wr),
    .key_data (pwdata[7:0]),
    .other_wr (wr_acc && !hit_key),
    .unlocked (unlocked)
  );

  // bus answer registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end
    else
    begin
      pready_q  <= acc;
      pslverr_q <= acc && !mapped;
      prdata_q  <= rd_acc ? rd_mux : 32'h0;
    end
  end

  // pointer and latch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ptr_q   <= '0;
      latch_q <= 8'h0;
    end
    else
    begin
      if (wr_acc && hit_ptr && !busy)
        ptr_q <= pwdata[21:0];
      else if ((tbl_rd || tbl_wr) && post_inc)
        ptr_q <= ptr_q + 22'h1; // [RULE2]
      if (tbl_rd)
        latch_q <= rd_byte; // [RULE1]
      else if (wr_acc && hit_lat)
        latch_q <= pwdata[7:0];
    end
  end

  // holding buffer: written only by table writes, never cleared by programming
  always_ff @(posedge pclk)
  begin
    if (tbl_wr)
      hold_q[ptr_q[5:0]] <= latch_q; // [RULE12] [RULE17]
  end

  // control bits; start is set-only from software
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      write_enable_bit_q   <= 1'b0;
      free_q   <= 1'b0;
      word_program_select_q <= 1'b0;
      wr_q     <= 1'b0;
      write_abort_flag_q  <= 1'b1;
    end
    else
    begin
      if (ctrl_wr)
      begin
        write_enable_bit_q   <= pwdata[`FSPS_BIT_WRITE_ENABLE_BIT];
        free_q   <= pwdata[`FSPS_BIT_FREE];
        word_program_select_q <= pwdata[`FSPS_BIT_WORD_PROGRAM_SELECT];
      end
      else if (state_q == FSPS_DONE && free_q)
        free_q <= 1'b0; // [RULE23]
      if (start_ok)
      begin
        wr_q    <= 1'b1; // [RULE20]
        write_abort_flag_q <= 1'b1; // [RULE21]
      end
      else if (start_req)
        write_abort_flag_q <= 1'b1; // [RULE21]
      else if (state_q == FSPS_DONE)
      begin
        wr_q    <= 1'b0; // [RULE20]
        write_abort_flag_q <= 1'b0; // [RULE21]
      end
    end
  end

  // long-write engine: the timer alone ends erase and program
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= FSPS_IDLE;
      tmr_q   <= 32'h0;
      idx_q   <= 7'h0;
    end
    else
    begin
      case (state_q)
        FSPS_IDLE:
          if (start_ok)
          begin
            state_q <= pwdata[`FSPS_BIT_FREE] ? FSPS_ERASE : FSPS_PROG; // [RULE10] [RULE16]
            tmr_q   <= pwdata[`FSPS_BIT_FREE] ? ERASE_CYC - 1 : WRITE_CYC - 1; // [RULE15]
            idx_q   <= 7'h0;
          end
        FSPS_ERASE:
        begin
          tmr_q <= tmr_q - 32'h1;
          if (tmr_end)
            state_q <= FSPS_DONE; // [RULE9]
        end
        FSPS_PROG:
        begin
          tmr_q <= tmr_q - 32'h1;
          // count saturates so a long timer cannot restream the block
          if (!idx_q[6])
            idx_q <= idx_q + 7'h1; // [RULE11]
          if (tmr_end)
            state_q <= FSPS_DONE;
        end
        FSPS_DONE:
          state_q <= FSPS_IDLE;
        default:
          state_q <= FSPS_IDLE;
      endcase
    end
  end

  // array-side outputs, registered; word mode streams two bytes, block mode 64
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      flash_addr  <= '0;
      flash_erase <= 1'b0;
      flash_prog  <= 1'b0;
      flash_word  <= 1'b0;
      flash_wdata <= 8'h0;
      flash_widx  <= 6'h0;
      pump_en     <= 1'b0;
      cpu_stall   <= 1'b0;
    end
    else
    begin
      flash_erase <= state_q == FSPS_ERASE; // [RULE4]
      flash_word  <= word_program_select_q; // [RULE22]
      flash_prog  <= state_q == FSPS_PROG &&
                     (word_program_select_q ? idx_q < 7'h2 : !idx_q[6]); // [RULE11]
      flash_widx  <= word_program_select_q ? {ptr_q[5:1], idx_q[0]} : idx_q[5:0];
      flash_wdata <= word_program_select_q ? hold_q[{ptr_q[5:1], idx_q[0]}] : hold_q[idx_q[5:0]];
      flash_addr  <= state_q == FSPS_ERASE ? erase_base :
                     state_q == FSPS_PROG  ? {ptr_q[21:6], 6'h0} : ptr_q;
      pump_en     <= state_q == FSPS_ERASE || state_q == FSPS_PROG; // [RULE15]
      cpu_stall   <= state_q == FSPS_ERASE || state_q == FSPS_PROG; // [RULE9]
    end
  end

  assign prdata  = prdata_q;
  assign pready  = pready_q;
  assign pslverr = pslverr_q;

  sequence s_start;
    state_q == FSPS_IDLE && start_ok;
  endsequence

  no_start_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE25]
    start_req && !pwdata[`FSPS_BIT_WRITE_ENABLE_BIT] |=> !wr_q || $past(wr_q))
    else $error("start accepted without write enable");
  key_needed_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE24]
    start_req && !unlocked && !busy |=> state_q == FSPS_IDLE)
    else $error("start accepted without key");
  erase_go_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE10]
    s_start and pwdata[`FSPS_BIT_FREE] |=> state_q == FSPS_ERASE ##1 cpu_stall)
    else $error("erase did not start");
  prog_go_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE16]
    s_start and !pwdata[`FSPS_BIT_FREE] |=> state_q == FSPS_PROG ##1 cpu_stall)
    else $error("program did not start");
  wr_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE20]
    state_q == FSPS_DONE |=> !wr_q && !write_abort_flag_q)
    else $error("start bit not cleared at end");
  wr_hold_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE20]
    wr_q && (state_q == FSPS_ERASE || state_q == FSPS_PROG) |=> wr_q)
    else $error("start bit lost during cycle");
  free_clear_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE23]
    state_q == FSPS_DONE && free_q && !ctrl_wr |=> !free_q)
    else $error("erase select not cleared");
  key_zero_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE23]
    rd_acc && hit_key |=> prdata == 32'h0)
    else $error("key register not zero");
  tbl_read_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE1]
    tbl_rd |=> latch_q == $past(rd_byte))
    else $error("table read wrong byte");
  erase_addr_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE5]
    state_q == FSPS_ERASE |=> flash_addr[9:0] == 10'h0)
    else $error("erase low bits not ignored");
  word_pair_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE22]
    state_q == FSPS_PROG && word_program_select_q && idx_q >= 7'h2 |=> !flash_prog)
    else $error("word program strobed past two bytes");
  block_unit_a: assert property (@(posedge pclk) disable iff (!presetn) // [RULE11]
    state_q == FSPS_PROG && !word_program_select_q && idx_q[6] |=> !flash_prog)
    else $error("block program strobed past 64 bytes");
endmodule // fsps_seq

// >>> fsps_flash_model.sv
// flash array model: word-wide array that answers reads in the same cycle
// assumes a byte address from the sequencer; bit 0 is ignored by the array
`timescale 1ns/1ps
module fsps_flash_model
(
  input  wire fsps_pkg::fsps_ptr_t addr,
  output logic [15:0]              rdata
);
  import fsps_pkg::*;
  // the contents are a pattern of the word address, so no preload is needed
  assign rdata = {~addr[8:1], addr[8:1]};
endmodule // fsps_flash_model

// >>> flash_self_program_sequencer_bench.sv
// bench for the flash self-program sequencer: apb master, flash model, monitors
// assumes short cycle parameters so that the erase and program runs stay brief
`timescale 1ns/1ps
`include "fsps_consts.svh"
module flash_self_program_sequencer_bench;
  import fsps_pkg::*;
  localparam int unsigned WCYC = 80;
  localparam int unsigned ECYC = 40;
  logic        pclk, presetn, psel, penable, pwrite, e;
  logic [7:0]  paddr, flash_wdata;
  logic [31:0] pwdata, prdata, r;
  logic        pready, pslverr, flash_erase, flash_prog, flash_word, pump_en, cpu_stall;
  fsps_ptr_t   flash_addr, exp_a;
  logic [15:0] flash_rdata;
  logic [7:0]  exp_hold [64];
  logic [5:0]  flash_widx;
  logic [63:0] seen;
  int          bad_count, compares, stall_n, prog_n;

  fsps_seq #(.WRITE_CYC(WCYC), .ERASE_CYC(ECYC)) uut
  (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_addr(flash_addr), .flash_rdata(flash_rdata), .flash_erase(flash_erase),
    .flash_prog(flash_prog), .flash_word(flash_word), .flash_wdata(flash_wdata),
    .flash_widx(flash_widx), .pump_en(pump_en), .cpu_stall(cpu_stall)
  );
  fsps_flash_model arr (.addr(flash_addr), .rdata(flash_rdata));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task test_done;
    $display("Counts: %0d mismatches, %0d compares", bad_count, compares);
    if (bad_count == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // samples at the edge, so outputs are seen as they stood before it
  always @(posedge pclk)
  begin
    if (cpu_stall === 1'b1)
      stall_n++;
    if ((flash_erase | flash_prog) === 1'b1)
      chk(32'(flash_addr), 32'(exp_a));
    if (flash_erase === 1'b1)
      chk(32'(pump_en & cpu_stall), 32'h1);
    if (flash_prog === 1'b1)
    begin
      prog_n++;
      seen[flash_widx] = 1'b1;
      chk(32'(flash_wdata), 32'(exp_hold[flash_widx]));
    end
  end

  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    if (n >= 20)
    begin
      bad_count++;
      test_done;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task key;
    bus(1'b1, `FSPS_OFF_KEY, 32'h55);
    bus(1'b1, `FSPS_OFF_KEY, 32'hAA);
  endtask

  task run_wait(input int lim);
    int n;
    n = 0;
    while (cpu_stall !== 1'b1 && n < 10)
    begin
      @(posedge pclk);
      n++;
    end
    while (cpu_stall === 1'b1 && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= lim)
    begin
      bad_count++;
      test_done;
    end
    @(posedge pclk);
  endtask

  task t_reset;
    bus(1'b0, `FSPS_OFF_CTRL, 32'h0);
    chk(r, 32'h08);
    bus(1'b0, `FSPS_OFF_KEY, 32'h0);
    chk(r, 32'h0);
    bus(1'b0, 8'h3C, 32'h0);
    chk(32'(e), 32'h1);
  endtask

  task t_read;
    fsps_ptr_t  p;
    logic [7:0] b;
    p = 22'h105;
    bus(1'b1, `FSPS_OFF_PTR, 32'(p));
    repeat (2)
    begin
      b = p[0] ? ~p[8:1] : p[8:1];
      bus(1'b1, `FSPS_OFF_TBLOP, 32'h5);
      bus(1'b0, `FSPS_OFF_LATCH, 32'h0);
      chk(r, 32'(b));
      p = p + 22'h1;
    end
    bus(1'b0, `FSPS_OFF_PTR, 32'h0);
    chk(r, 32'(p));
    bus(1'b1, `FSPS_OFF_TBLOP, 32'h1);
    bus(1'b0, `FSPS_OFF_PTR, 32'h0);
    chk(r, 32'(p));
  endtask

  task t_erase;
    fsps_ptr_t p;
    p = 22'h12F3C5;
    exp_a = {p[21:10], 10'h000};
    bus(1'b1, `FSPS_OFF_PTR, 32'(p));
    bus(1'b1, `FSPS_OFF_CTRL, 32'h14);
    key;
    stall_n = 0;
    bus(1'b1, `FSPS_OFF_CTRL, 32'h16);
    run_wait(200);
    chk(32'(stall_n >= ECYC && stall_n <= ECYC + 2), 32'h1);
    bus(1'b0, `FSPS_OFF_CTRL, 32'h0);
    chk(r & 32'h3E, 32'h04);
    bus(1'b0, `FSPS_OFF_STATUS, 32'h0);
    chk(r, 32'h0);
  endtask

  task t_refuse;
    stall_n = 0;
    bus(1'b1, `FSPS_OFF_CTRL, 32'h06);
    bus(1'b0, `FSPS_OFF_CTRL, 32'h0);
    chk(r & 32'h0A, 32'h08);
    key;
    bus(1'b1, `FSPS_OFF_PTR, 32'h40);
    bus(1'b1, `FSPS_OFF_CTRL, 32'h06);
    key;
    bus(1'b1, `FSPS_OFF_CTRL, 32'h02);
    repeat (4) @(posedge pclk);
    chk(stall_n, 32'h0);
  endtask

  task t_prog;
    int i;
    bus(1'b1, `FSPS_OFF_PTR, 32'h1040);
    for (i = 0; i < 64; i++)
    begin
      exp_hold[i] = 8'(i * 3 + 1);
      bus(1'b1, `FSPS_OFF_LATCH, 32'(exp_hold[i]));
      bus(1'b1, `FSPS_OFF_TBLOP, 32'h6);
    end
    bus(1'b1, `FSPS_OFF_PTR, 32'h107F);
    exp_a = 22'h1040;
    bus(1'b1, `FSPS_OFF_CTRL, 32'h04);
    key;
    stall_n = 0;
    seen = '0;
    prog_n = 0;
    bus(1'b1, `FSPS_OFF_CTRL, 32'h06);
    run_wait(400);
    chk(32'(&seen), 32'h1);
    chk(32'(stall_n >= WCYC && stall_n <= WCYC + 2), 32'h1);
    chk(prog_n, 32'h40);
    chk(32'(flash_word), 32'h0);
    bus(1'b1, `FSPS_OFF_PTR, 32'h1083);
    exp_a = 22'h1080;
    bus(1'b1, `FSPS_OFF_CTRL, 32'h24);
    key;
    prog_n = 0;
    bus(1'b1, `FSPS_OFF_CTRL, 32'h26);
    run_wait(400);
    chk(prog_n, 32'h2);
    chk(32'(flash_word), 32'h1);
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    exp_a = '0;
    seen = '0;
    bad_count = 0;
    compares = 0;
    stall_n = 0;
    prog_n = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_reset;
    t_read;
    t_erase;
    t_refuse;
    t_prog;
    test_done;
  end
endmodule // flash_self_program_sequencer_bench
